// ---- hdl/cibalu_pkg.sv ----
// Package: operation codes, flag layout, widths and reset values of the integer/bit ALU
package cibalu_pkg;

    localparam int unsigned DATA_W    = 16;
    localparam int unsigned BITIDX_W  = 4;
    localparam int unsigned DIV_STEPS = 16;
    localparam int unsigned DIVCNT_W  = 5;

    // Flag vector positions
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;

    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [3:0]  RST_FLAGS = 4'h0;
    localparam logic [4:0]  RST_CNT   = 5'h00;
    localparam logic [4:0]  DIV_LAST  = 5'h0F;

    typedef enum logic [4:0] {
        CIB_OP_ADD,
        CIB_OP_ADD_CARRY,
        CIB_OP_SUB,
        CIB_OP_SUB_CARRY,
        CIB_OP_MUL,
        CIB_OP_DIV,
        CIB_OP_LONG_DIV,
        CIB_OP_CPL,
        CIB_OP_NEG,
        CIB_OP_AND,
        CIB_OP_OR,
        CIB_OP_XOR,
        CIB_OP_BIT_CLR,
        CIB_OP_BIT_SET,
        CIB_OP_BIT_MOV,
        CIB_OP_BIT_MOVN,
        CIB_OP_BIT_AND,
        CIB_OP_BIT_OR,
        CIB_OP_BIT_XOR,
        CIB_OP_BIT_CMP,
        CIB_OP_FIELD_HI,
        CIB_OP_FIELD_LO,
        CIB_OP_CMP,
        CIB_OP_CMP_DEC1,
        CIB_OP_CMP_DEC2,
        CIB_OP_CMP_INC1,
        CIB_OP_CMP_INC2,
        CIB_OP_NORM,
        CIB_OP_SHL,
        CIB_OP_SHR
    } cibalu_op_t;

endpackage

// ---- hdl/cibalu_divider.sv ----
// Restoring 32/16 divider, one quotient bit per clock
`timescale 1ns/1ns
module cibalu_divider #(
    parameter int unsigned W = 16
) (
    input  wire logic              CLK,
    input  wire logic              NRST,
    input  wire logic              CE,
    input  wire logic              start,
    input  wire logic              is_signed,
    input  wire logic [2*W-1:0]    dividend,
    input  wire logic [W-1:0]      divisor,
    output logic                   done,
    output logic [W-1:0]           quotient,
    output logic [W-1:0]           remainder,
    output logic                   overflow
);
    import cibalu_pkg::*;

    typedef struct packed {
        logic              busy;
        logic              done;
        logic [4:0]        cnt;
        logic [2*W-1:0]    num;
        logic [W:0]        rem;
        logic [W-1:0]      den;
        logic              neg_q;
        logic              neg_r;
        logic              ovf;
    } cibdiv_state_t;

    cibdiv_state_t st;
    cibdiv_state_t next_st;

    logic [2*W-1:0] mag_num;
    logic [W-1:0]   mag_den;
    logic [W:0]     trial;
    logic [W:0]     shifted;
    logic [W-1:0]   q_raw;
    logic [W-1:0]   r_raw;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        mag_num = (is_signed && dividend[2*W-1]) ? (~dividend + 1'b1) : dividend;
        mag_den = (is_signed && divisor[W-1]) ? (~divisor + 1'b1) : divisor;
        shifted = {st.rem[W-1:0], st.num[2*W-1]};
        trial = shifted - {1'b0, st.den};
        if (start) begin
            next_st.busy  = 1'b1;
            next_st.cnt   = RST_CNT;
            // High half seeds the remainder, low half is shifted in
            next_st.rem   = {1'b0, mag_num[2*W-1:W]};
            next_st.num   = {mag_num[W-1:0], {W{1'b0}}};
            next_st.den   = mag_den;
            next_st.neg_q = is_signed && (dividend[2*W-1] ^ divisor[W-1]);
            next_st.neg_r = is_signed && dividend[2*W-1];
            // Divide by zero, or quotient that cannot fit in one word
            next_st.ovf   = (mag_den == '0) || (mag_num[2*W-1:W] >= mag_den);
        end else if (st.busy) begin
            next_st.num = {st.num[2*W-2:0], ~trial[W]};
            next_st.rem = trial[W] ? shifted : trial;
            next_st.cnt = 5'(st.cnt + 5'h01);
            if (st.cnt == DIV_LAST) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st <= '0;
        end else if (CE) begin
            st <= next_st;
        end
    end

    assign q_raw     = st.num[W-1:0];
    assign r_raw     = st.rem[W-1:0];
    assign done      = st.done;
    assign quotient  = st.neg_q ? (~q_raw + 1'b1) : q_raw;
    assign remainder = st.neg_r ? (~r_raw + 1'b1) : r_raw;
    assign overflow  = st.ovf;

endmodule // cibalu_divider

// ---- hdl/cibalu_top.sv ----
// Integer and bit-manipulation execution datapath of a 16-bit core
`timescale 1ns/1ns

module cibalu_top #(
    parameter int unsigned DATA_WIDTH = cibalu_pkg::DATA_W
) (
    input  wire logic                         CLK,
    input  wire logic                         NRST,
    input  wire logic                         CE,
    input  wire logic                         START,
    input  wire cibalu_pkg::cibalu_op_t       OP,
    input  wire logic                         BYTE_MODE,
    input  wire logic                         SIGNED_MODE,
    input  wire logic [DATA_WIDTH-1:0]        OPA,
    input  wire logic [DATA_WIDTH-1:0]        OPB,
    input  wire logic [cibalu_pkg::BITIDX_W-1:0] SRC_BIT,
    input  wire logic [cibalu_pkg::BITIDX_W-1:0] DST_BIT,
    input  wire logic [7:0]                   FIELD_MASK,
    input  wire logic [7:0]                   FIELD_DATA,
    input  wire logic [3:0]                   SHIFT_COUNT,
    output logic                              DONE,
    output logic                              BUSY,
    output logic [DATA_WIDTH-1:0]             RESULT,
    output logic                              RESULT_WE,
    output logic [DATA_WIDTH-1:0]             STEP_RESULT,
    output logic                              STEP_WE,
    output logic [2*DATA_WIDTH-1:0]           MULDIV,
    output logic [3:0]                        FLAGS
);
    import cibalu_pkg::*;

    typedef struct packed {
        logic                    done;
        logic                    busy;
        logic [DATA_WIDTH-1:0]   result;
        logic                    result_we;
        logic [DATA_WIDTH-1:0]   step;
        logic                    step_we;
        logic [2*DATA_WIDTH-1:0] muldiv;
        logic                    long_div;
        logic [3:0]              flags;
    } cibalu_state_t;

    cibalu_state_t st;
    cibalu_state_t next_st;

    logic                  div_start;
    logic                  div_done;
    logic [DATA_WIDTH-1:0] div_q;
    logic [DATA_WIDTH-1:0] div_r;
    logic                  div_ovf;
    logic [2*DATA_WIDTH-1:0] div_num;

    // Short divide extends the low half to a full dividend
    assign div_num = (OP == CIB_OP_LONG_DIV) ? st.muldiv :
        {{DATA_WIDTH{SIGNED_MODE & st.muldiv[DATA_WIDTH-1]}}, st.muldiv[DATA_WIDTH-1:0]};
    assign div_start = START && !st.busy && (OP == CIB_OP_DIV || OP == CIB_OP_LONG_DIV);

    cibalu_divider #(
        .W(DATA_WIDTH)
    ) u_div (
        .CLK      (CLK),
        .NRST     (NRST),
        .CE       (CE),
        .start    (div_start),
        .is_signed(SIGNED_MODE),
        .dividend (div_num),
        .divisor  (OPB),
        .done     (div_done),
        .quotient (div_q),
        .remainder(div_r),
        .overflow (div_ovf)
    );

    logic [DATA_WIDTH:0]     sum;
    logic [DATA_WIDTH-1:0]   res;
    logic [DATA_WIDTH-1:0]   a_in;
    logic [DATA_WIDTH-1:0]   b_in;
    logic                    c_in;
    logic                    is_sub;
    logic                    arith;
    logic                    write_res;
    logic                    cout;
    logic                    vout;
    logic [DATA_WIDTH-1:0]   bitmask;
    logic                    sbit;
    logic                    dbit;
    logic [2*DATA_WIDTH-1:0] prod;
    logic [4:0]              norm_cnt;
    logic [DATA_WIDTH-1:0]   field_m;
    logic [DATA_WIDTH-1:0]   field_d;
    logic [DATA_WIDTH:0]     shl_full;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.result_we = 1'b0;
        next_st.step_we = 1'b0;
        a_in = OPA;
        b_in = OPB;
        c_in = 1'b0;
        is_sub = 1'b0;
        arith = 1'b0;
        write_res = 1'b1;
        res = OPA;
        cout = st.flags[FLAG_C];
        vout = 1'b0;
        sbit = OPB[SRC_BIT];
        dbit = OPA[DST_BIT];
        bitmask = '0;
        bitmask[DST_BIT] = 1'b1;
        prod = '0;
        norm_cnt = RST_CNT;
        field_m = '0;
        field_d = '0;
        shl_full = '0;
        sum = '0;
        case (OP)
            CIB_OP_ADD:       begin arith = 1'b1; end
            CIB_OP_ADD_CARRY: begin arith = 1'b1; c_in = st.flags[FLAG_C]; end
            CIB_OP_SUB:       begin arith = 1'b1; is_sub = 1'b1; end
            CIB_OP_SUB_CARRY: begin arith = 1'b1; is_sub = 1'b1; c_in = st.flags[FLAG_C]; end
            CIB_OP_NEG:       begin arith = 1'b1; is_sub = 1'b1; a_in = '0; b_in = OPA; end
            CIB_OP_CMP:       begin arith = 1'b1; is_sub = 1'b1; write_res = 1'b0; end
            CIB_OP_CMP_DEC1, CIB_OP_CMP_DEC2, CIB_OP_CMP_INC1, CIB_OP_CMP_INC2: begin
                arith = 1'b1;
                is_sub = 1'b1;
                write_res = 1'b0;
            end
            default: ;
        endcase
        // Byte operands sit in the low byte; top byte is zeroed so the sum carries at bit 8
        if (BYTE_MODE && arith) begin
            a_in = {8'h00, a_in[7:0]};
            b_in = {8'h00, b_in[7:0]};
        end
        if (arith) begin
            // Subtraction borrows through the carry flag
            if (is_sub) begin
                sum = {1'b0, a_in} - {1'b0, b_in} - {{DATA_WIDTH{1'b0}}, c_in};
            end else begin
                sum = {1'b0, a_in} + {1'b0, b_in} + {{DATA_WIDTH{1'b0}}, c_in};
            end
            res = sum[DATA_WIDTH-1:0];
        end
        case (OP)
            CIB_OP_CPL: res = ~OPA;
            CIB_OP_AND: res = OPA & OPB;
            CIB_OP_OR:  res = OPA | OPB;
            CIB_OP_XOR: res = OPA ^ OPB;
            CIB_OP_BIT_CLR:  res = OPA & ~bitmask;
            CIB_OP_BIT_SET:  res = OPA | bitmask;
            CIB_OP_BIT_MOV:  res = sbit ? (OPA | bitmask) : (OPA & ~bitmask);
            CIB_OP_BIT_MOVN: res = sbit ? (OPA & ~bitmask) : (OPA | bitmask);
            CIB_OP_BIT_AND:  res = (dbit & sbit) ? (OPA | bitmask) : (OPA & ~bitmask);
            CIB_OP_BIT_OR:   res = (dbit | sbit) ? (OPA | bitmask) : (OPA & ~bitmask);
            CIB_OP_BIT_XOR:  res = (dbit ^ sbit) ? (OPA | bitmask) : (OPA & ~bitmask);
            CIB_OP_BIT_CMP:  write_res = 1'b0;
            CIB_OP_FIELD_HI, CIB_OP_FIELD_LO: begin
                field_m = (OP == CIB_OP_FIELD_HI) ? {FIELD_MASK, 8'h00} : {8'h00, FIELD_MASK};
                field_d = (OP == CIB_OP_FIELD_HI) ? {FIELD_DATA, 8'h00} : {8'h00, FIELD_DATA};
                res = (OPA & ~field_m) | (field_d & field_m);
            end
            CIB_OP_NORM: begin
                // Highest set bit is found last
                for (int i = DATA_WIDTH - 1; i >= 0; i--) begin
                    if (OPA[DATA_WIDTH-1-i]) begin
                        norm_cnt = 5'(i);
                    end
                end
                res = (OPA == '0) ? '0 : {11'h000, norm_cnt};
            end
            CIB_OP_SHL: begin
                shl_full = {1'b0, OPA} << SHIFT_COUNT;
                res = shl_full[DATA_WIDTH-1:0];
                cout = (SHIFT_COUNT == 4'h0) ? 1'b0 : shl_full[DATA_WIDTH];
            end
            CIB_OP_SHR: begin
                res = OPA >> SHIFT_COUNT;
                cout = (SHIFT_COUNT == 4'h0) ? 1'b0 : OPA[SHIFT_COUNT - 4'h1];
            end
            CIB_OP_MUL, CIB_OP_DIV, CIB_OP_LONG_DIV: write_res = 1'b0;
            default: ;
        endcase
        if (arith) begin
            cout = BYTE_MODE ? sum[8] : sum[DATA_WIDTH];
            vout = BYTE_MODE ? ((a_in[7] ^ res[7]) & ~(a_in[7] ^ b_in[7] ^ is_sub))
                             : ((a_in[DATA_WIDTH-1] ^ res[DATA_WIDTH-1])
                                & ~(a_in[DATA_WIDTH-1] ^ b_in[DATA_WIDTH-1] ^ is_sub));
        end
        // Byte results of add, subtract, complement, negate and logic ops keep the high byte of the destination
        if (BYTE_MODE && OP inside {CIB_OP_ADD, CIB_OP_ADD_CARRY, CIB_OP_SUB, CIB_OP_SUB_CARRY,
            CIB_OP_CPL, CIB_OP_NEG, CIB_OP_AND, CIB_OP_OR, CIB_OP_XOR}) begin
            res = {OPA[DATA_WIDTH-1:8], res[7:0]};
        end
        if (START && !st.busy) begin
            case (OP)
                CIB_OP_MUL: begin
                    prod = {{DATA_WIDTH{SIGNED_MODE & OPA[DATA_WIDTH-1]}}, OPA} *
                           {{DATA_WIDTH{SIGNED_MODE & OPB[DATA_WIDTH-1]}}, OPB};
                    next_st.muldiv = prod;
                    next_st.flags[FLAG_Z] = (prod == '0);
                    next_st.flags[FLAG_N] = SIGNED_MODE & prod[2*DATA_WIDTH-1];
                    next_st.flags[FLAG_C] = 1'b0;
                    next_st.flags[FLAG_V] = 1'b0;
                    next_st.done = 1'b1;
                end
                CIB_OP_DIV, CIB_OP_LONG_DIV: begin
                    next_st.busy = 1'b1;
                    next_st.long_div = (OP == CIB_OP_LONG_DIV);
                end
                default: begin
                    next_st.result = res;
                    next_st.result_we = write_res;
                    next_st.flags[FLAG_C] = (OP == CIB_OP_BIT_CMP) ? 1'b0 : cout;
                    next_st.flags[FLAG_V] = (OP == CIB_OP_BIT_CMP) ? (dbit ^ sbit) : vout;
                    if (OP == CIB_OP_BIT_CMP) begin
                        next_st.flags[FLAG_Z] = ~(dbit | sbit);
                        next_st.flags[FLAG_N] = dbit ^ sbit;
                    end else begin
                        next_st.flags[FLAG_Z] = BYTE_MODE ? (res[7:0] == 8'h00) : (res == '0);
                        next_st.flags[FLAG_N] = BYTE_MODE ? res[7] : res[DATA_WIDTH-1];
                    end
                    case (OP)
                        CIB_OP_CMP_DEC1: next_st.step = OPA - 16'h0001;
                        CIB_OP_CMP_DEC2: next_st.step = OPA - 16'h0002;
                        CIB_OP_CMP_INC1: next_st.step = OPA + 16'h0001;
                        CIB_OP_CMP_INC2: next_st.step = OPA + 16'h0002;
                        default: ;
                    endcase
                    next_st.step_we = (OP == CIB_OP_CMP_DEC1 || OP == CIB_OP_CMP_DEC2 ||
                                       OP == CIB_OP_CMP_INC1 || OP == CIB_OP_CMP_INC2);
                    next_st.done = 1'b1;
                end
            endcase
        end
        if (st.busy && div_done) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
            // Quotient goes to the low half, remainder to the high half
            next_st.muldiv = {div_r, div_q};
            next_st.flags[FLAG_V] = div_ovf;
            next_st.flags[FLAG_Z] = (div_q == '0);
            next_st.flags[FLAG_N] = div_q[DATA_WIDTH-1];
            next_st.flags[FLAG_C] = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st <= '0;
        end else if (CE) begin
            st <= next_st;
        end
    end

    assign DONE        = st.done;
    assign BUSY        = st.busy;
    assign RESULT      = st.result;
    assign RESULT_WE   = st.result_we;
    assign STEP_RESULT = st.step;
    assign STEP_WE     = st.step_we;
    assign MULDIV      = st.muldiv;
    assign FLAGS       = st.flags;

endmodule // cibalu_top

// ---- test/cibalu_chk.sv ----
// Port-level assertions of the integer/bit ALU
`timescale 1ns/1ns
module cibalu_chk #(
    parameter int unsigned DATA_WIDTH = cibalu_pkg::DATA_W
) (
    input wire logic                    CLK,
    input wire logic                    NRST,
    input wire logic                    CE,
    input wire logic                    START,
    input wire cibalu_pkg::cibalu_op_t  OP,
    input wire logic                    BYTE_MODE,
    input wire logic                    SIGNED_MODE,
    input wire logic [DATA_WIDTH-1:0]   OPA,
    input wire logic [DATA_WIDTH-1:0]   OPB,
    input wire logic                    DONE,
    input wire logic                    BUSY,
    input wire logic [DATA_WIDTH-1:0]   RESULT,
    input wire logic                    RESULT_WE,
    input wire logic [DATA_WIDTH-1:0]   STEP_RESULT,
    input wire logic                    STEP_WE,
    input wire logic [2*DATA_WIDTH-1:0] MULDIV,
    input wire logic [3:0]              FLAGS
);
    import cibalu_pkg::*;

    cibalu_op_t              lop;
    logic [DATA_WIDTH-1:0]   la;
    logic [DATA_WIDTH-1:0]   lb;
    logic [2*DATA_WIDTH-1:0] lmd;
    logic                    lbyte;
    logic                    lsgn;
    logic [4:0]              busy_cnt;
    logic                    take;
    logic                    is_div;

    assign take   = CE && START && !BUSY;
    assign is_div = (OP == CIB_OP_DIV) || (OP == CIB_OP_LONG_DIV);

    // Latch accepted requests; count divide cycles
    always_ff @(posedge CLK) begin
        if (take) begin
            lop   <= OP;
            la    <= OPA;
            lb    <= OPB;
            lmd   <= MULDIV;
            lbyte <= BYTE_MODE;
            lsgn  <= SIGNED_MODE;
        end
        if (!BUSY)
            busy_cnt <= 5'h00;
        else if (CE)
            busy_cnt <= busy_cnt + 5'h01;
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);

    AST_NONDIV_DONE: assert property (take && !is_div |=> DONE)
        else $error("no answer one cycle after a request");
    AST_DIV_BUSY: assert property (take && is_div |=> BUSY && !DONE)
        else $error("divide did not go busy");
    AST_DIV_LEN: assert property ($fell(BUSY) |-> DONE && busy_cnt == 5'h11)
        else $error("divide length wrong");
    AST_ADD_SUM: assert property (DONE && lop == CIB_OP_ADD && !lbyte |-> RESULT == la + lb)
        else $error("word sum wrong");
    AST_BYTE_KEEP: assert property (DONE && lbyte && RESULT_WE && lop inside {CIB_OP_ADD,
        CIB_OP_SUB, CIB_OP_AND, CIB_OP_OR, CIB_OP_XOR, CIB_OP_CPL, CIB_OP_NEG}
        |-> RESULT[15:8] == la[15:8])
        else $error("byte operation touched high byte");
    AST_CMP_NOWB: assert property (DONE && lop inside {CIB_OP_CMP, CIB_OP_BIT_CMP} |-> !RESULT_WE)
        else $error("compare wrote a result");
    AST_STEP_WE: assert property (DONE && lop inside {CIB_OP_CMP_DEC1, CIB_OP_CMP_DEC2}
        |-> STEP_WE && STEP_RESULT == la - ((lop == CIB_OP_CMP_DEC2) ? 16'h0002 : 16'h0001))
        else $error("step down wrong");
    AST_STEP_UP: assert property (DONE && lop == CIB_OP_CMP_INC2 |-> STEP_RESULT == la + 16'h0002)
        else $error("step up by two wrong");
    AST_MULTIPLY_OP: assert property (DONE && lop == CIB_OP_MUL && !lsgn
        |-> MULDIV == {{DATA_WIDTH{1'b0}}, la} * {{DATA_WIDTH{1'b0}}, lb})
        else $error("unsigned product wrong");
    AST_LDIV: assert property (DONE && lop == CIB_OP_LONG_DIV && !lsgn && lmd[31:16] < lb
        |-> MULDIV[15:0] * lb + MULDIV[31:16] == lmd && MULDIV[31:16] < lb)
        else $error("long divide wrong");
    AST_XOR_Z: assert property (DONE && lop == CIB_OP_XOR
        |-> FLAGS[FLAG_Z] == (lbyte ? RESULT[7:0] == 8'h00 : RESULT == 16'h0000))
        else $error("zero flag wrong");

    COV_DIV: cover property ($fell(BUSY));
    COV_REFUSED: cover property (START && BUSY);
    COV_STEP: cover property (STEP_WE);
endmodule // cibalu_chk

bind cibalu_top cibalu_chk #(.DATA_WIDTH(DATA_WIDTH)) cibalu_chk_inst (
    .CLK(CLK), .NRST(NRST), .CE(CE), .START(START), .OP(OP), .BYTE_MODE(BYTE_MODE),
    .SIGNED_MODE(SIGNED_MODE), .OPA(OPA), .OPB(OPB), .DONE(DONE), .BUSY(BUSY),
    .RESULT(RESULT), .RESULT_WE(RESULT_WE), .STEP_RESULT(STEP_RESULT), .STEP_WE(STEP_WE),
    .MULDIV(MULDIV), .FLAGS(FLAGS));

// ---- test/cibalu_rf_model.sv ----
// Write-back side of the register file facing the ALU
`timescale 1ns/1ns
module cibalu_rf_model (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        result_we,
    input  wire logic        step_we,
    input  wire logic [15:0] step_result,
    output int unsigned      wb_count,
    output int unsigned      step_count,
    output logic [15:0]      last_step
);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wb_count   <= 0;
            step_count <= 0;
            last_step  <= 16'h0000;
        end else begin
            if (result_we)
                wb_count <= wb_count + 1;
            if (step_we) begin
                step_count <= step_count + 1;
                last_step  <= step_result;
            end
        end
    end
endmodule // cibalu_rf_model

// ---- test/tb.sv ----
// Self-checking testbench of the integer/bit ALU
`timescale 1ns/1ns
module tb;
    import cibalu_pkg::*;

    logic        CLK = 1'b0;
    logic        NRST = 1'b0;
    logic        CE = 1'b1;
    logic        START = 1'b0;
    cibalu_op_t  OP = CIB_OP_ADD;
    logic        BYTE_MODE = 1'b0;
    logic        SIGNED_MODE = 1'b0;
    logic [15:0] OPA = 16'h0000;
    logic [15:0] OPB = 16'h0000;
    logic [3:0]  SRC_BIT = 4'h0;
    logic [3:0]  DST_BIT = 4'h0;
    logic [7:0]  FIELD_MASK = 8'h00;
    logic [7:0]  FIELD_DATA = 8'h00;
    logic [3:0]  SHIFT_COUNT = 4'h0;
    logic        DONE, BUSY, RESULT_WE, STEP_WE;
    logic [15:0] RESULT, STEP_RESULT, last_step;
    logic [31:0] MULDIV;
    logic [3:0]  FLAGS;
    int unsigned wb_count, step_count;
    int          miscompares = 0;
    int          n_checks = 0;
    int          cyc;

    cibalu_top #(.DATA_WIDTH(16)) cibalu_top_inst (
        .CLK(CLK), .NRST(NRST), .CE(CE), .START(START), .OP(OP), .BYTE_MODE(BYTE_MODE),
        .SIGNED_MODE(SIGNED_MODE), .OPA(OPA), .OPB(OPB), .SRC_BIT(SRC_BIT), .DST_BIT(DST_BIT),
        .FIELD_MASK(FIELD_MASK), .FIELD_DATA(FIELD_DATA), .SHIFT_COUNT(SHIFT_COUNT),
        .DONE(DONE), .BUSY(BUSY), .RESULT(RESULT), .RESULT_WE(RESULT_WE),
        .STEP_RESULT(STEP_RESULT), .STEP_WE(STEP_WE), .MULDIV(MULDIV), .FLAGS(FLAGS));
    cibalu_rf_model cibalu_rf_model_inst (
        .clk(CLK), .nrst(NRST), .result_we(RESULT_WE), .step_we(STEP_WE),
        .step_result(STEP_RESULT), .wb_count(wb_count), .step_count(step_count),
        .last_step(last_step));

    always #2 CLK = ~CLK;

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_done(output int n);
        n = 0;
        while (DONE !== 1'b1 && n < 40) begin
            @(negedge CLK);
            n++;
        end
        if (n >= 40) begin
            miscompares++;
            close_out();
        end
    endtask

    task automatic go(input cibalu_op_t o);
        @(negedge CLK);
        OP = o;
        START = 1'b1;
        @(negedge CLK);
        START = 1'b0;
    endtask

    task automatic run(input cibalu_op_t o);
        go(o);
        wait_done(cyc);
    endtask

    task automatic t(input cibalu_op_t o, input logic [15:0] a, b, e);
        OPA = a;
        OPB = b;
        run(o);
        chk({RESULT_WE, RESULT}, {1'b1, e});
    endtask

    task automatic ts(input cibalu_op_t o, input logic [15:0] a, e);
        OPA = a;
        run(o);
        chk({STEP_WE, STEP_RESULT}, {1'b1, e});
    endtask

    task automatic s_arith;
        t(CIB_OP_ADD, 16'hFFFF, 16'h0001, 16'h0000);
        chk(FLAGS[FLAG_C] & FLAGS[FLAG_Z], 1'b1);
        t(CIB_OP_ADD_CARRY, 16'h0001, 16'h0001, 16'h0003);
        t(CIB_OP_SUB, 16'h0000, 16'h0001, 16'hFFFF);
        chk(FLAGS[FLAG_C] & FLAGS[FLAG_N], 1'b1);
        t(CIB_OP_SUB_CARRY, 16'h0005, 16'h0001, 16'h0003);
        t(CIB_OP_ADD, 16'h7FFF, 16'h0001, 16'h8000);
        chk(FLAGS[FLAG_V], 1'b1);
        BYTE_MODE = 1'b1;
        t(CIB_OP_ADD, 16'h12FF, 16'h0001, 16'h1200);
        chk(FLAGS[FLAG_C], 1'b1);
        t(CIB_OP_SUB_CARRY, 16'h3400, 16'h0000, 16'h34FF);
        BYTE_MODE = 1'b0;
    endtask

    task automatic s_logic;
        OPA = 16'hF0F0;
        OPB = 16'h3C3C;
        @(negedge CLK);
        OP = CIB_OP_AND;
        START = 1'b1;
        @(negedge CLK);
        chk({DONE, RESULT}, {1'b1, 16'h3030});
        OP = CIB_OP_OR;
        @(negedge CLK);
        chk({DONE, RESULT}, {1'b1, 16'hFCFC});
        START = 1'b0;
        t(CIB_OP_CPL, 16'h00FF, 16'h0000, 16'hFF00);
        t(CIB_OP_NEG, 16'h0001, 16'h0000, 16'hFFFF);
        BYTE_MODE = 1'b1;
        t(CIB_OP_CPL, 16'h3401, 16'h0000, 16'h34FE);
        t(CIB_OP_NEG, 16'h3401, 16'h0000, 16'h34FF);
        t(CIB_OP_XOR, 16'h56AA, 16'h00AA, 16'h5600);
        chk(FLAGS[FLAG_Z], 1'b1);
        BYTE_MODE = 1'b0;
    endtask

    task automatic s_bits;
        SRC_BIT = 4'h3;
        DST_BIT = 4'h7;
        t(CIB_OP_BIT_SET, 16'h0000, 16'h0000, 16'h0080);
        t(CIB_OP_BIT_CLR, 16'hFFFF, 16'h0000, 16'hFF7F);
        t(CIB_OP_BIT_MOV, 16'h0000, 16'h0008, 16'h0080);
        t(CIB_OP_BIT_MOVN, 16'h0080, 16'h0008, 16'h0000);
        t(CIB_OP_BIT_AND, 16'h0080, 16'hFFF7, 16'h0000);
        t(CIB_OP_BIT_OR, 16'h1200, 16'h0008, 16'h1280);
        t(CIB_OP_BIT_XOR, 16'h0080, 16'h0008, 16'h0000);
        OPA = 16'h0000;
        run(CIB_OP_BIT_CMP);
        chk({RESULT_WE, FLAGS[FLAG_Z], FLAGS[FLAG_N]}, 3'b001);
    endtask

    task automatic s_field;
        FIELD_MASK = 8'h0F;
        FIELD_DATA = 8'hA5;
        t(CIB_OP_FIELD_HI, 16'hFFFF, 16'h0000, 16'hF5FF);
        t(CIB_OP_FIELD_LO, 16'h0000, 16'h0000, 16'h0005);
    endtask

    task automatic s_cmp;
        int unsigned w;
        int unsigned s;
        @(negedge CLK);
        w = wb_count;
        s = step_count;
        OPA = 16'h1234;
        OPB = 16'h1234;
        run(CIB_OP_CMP);
        chk({RESULT_WE, FLAGS[FLAG_Z]}, 2'b01);
        BYTE_MODE = 1'b1;
        OPA = 16'h5612;
        OPB = 16'h7812;
        run(CIB_OP_CMP);
        chk({RESULT_WE, FLAGS[FLAG_Z]}, 2'b01);
        BYTE_MODE = 1'b0;
        @(negedge CLK);
        chk(wb_count, w);
        ts(CIB_OP_CMP_DEC1, 16'h0000, 16'hFFFF);
        ts(CIB_OP_CMP_DEC2, 16'h0001, 16'hFFFF);
        ts(CIB_OP_CMP_INC1, 16'hFFFF, 16'h0000);
        ts(CIB_OP_CMP_INC2, 16'hFFFF, 16'h0001);
        @(negedge CLK);
        chk({step_count - s, 16'h0000, last_step}, {32'd4, 32'h00000001});
    endtask

    task automatic s_shift;
        SHIFT_COUNT = 4'h1;
        t(CIB_OP_SHL, 16'h8001, 16'h0000, 16'h0002);
        chk(FLAGS[FLAG_C], 1'b1);
        t(CIB_OP_SHR, 16'h8002, 16'h0000, 16'h4001);
        chk(FLAGS[FLAG_C], 1'b0);
        SHIFT_COUNT = 4'hF;
        t(CIB_OP_SHL, 16'h0001, 16'h0000, 16'h8000);
        t(CIB_OP_NORM, 16'h0001, 16'h0000, 16'h000F);
        t(CIB_OP_NORM, 16'h0300, 16'h0000, 16'h0006);
        t(CIB_OP_NORM, 16'h8001, 16'h0000, 16'h0000);
        t(CIB_OP_NORM, 16'h0000, 16'h0000, 16'h0000);
    endtask

    task automatic s_muldiv;
        OPA = 16'hFFFF;
        OPB = 16'hFFFF;
        run(CIB_OP_MUL);
        chk({RESULT_WE, FLAGS[FLAG_C], FLAGS[FLAG_V], MULDIV}, {3'b000, 32'hFFFE0001});
        SIGNED_MODE = 1'b1;
        run(CIB_OP_MUL);
        chk(MULDIV, 32'h00000001);
        OPA = 16'hFF9C;
        OPB = 16'h0001;
        run(CIB_OP_MUL);
        OPB = 16'h0007;
        run(CIB_OP_DIV);
        chk({cyc, MULDIV[15:0]}, {32'd17, 16'hFFF2});
        SIGNED_MODE = 1'b0;
        OPA = 16'h1000;
        OPB = 16'h0010;
        run(CIB_OP_MUL);
        OPB = 16'h0003;
        run(CIB_OP_LONG_DIV);
        chk(MULDIV, 32'h00015555);
        OPB = 16'h0000;
        run(CIB_OP_DIV);
        chk(FLAGS[FLAG_V], 1'b1);
    endtask

    // Divide with a refused request and a stall
    task automatic s_stall;
        OPA = 16'h0064;
        OPB = 16'h0001;
        run(CIB_OP_MUL);
        OPB = 16'h0007;
        go(CIB_OP_DIV);
        chk(BUSY, 1'b1);
        @(negedge CLK);
        OP = CIB_OP_ADD;
        START = 1'b1;
        @(negedge CLK);
        START = 1'b0;
        CE = 1'b0;
        repeat (3) @(negedge CLK);
        CE = 1'b1;
        wait_done(cyc);
        chk({cyc[7:0], BUSY, MULDIV}, {8'd15, 1'b0, 32'h0002000E});
    endtask

    initial begin
        repeat (8) @(negedge CLK);
        chk({DONE, BUSY, RESULT_WE, STEP_WE, FLAGS, RESULT, MULDIV}, 64'h0);
        NRST = 1'b1;
        s_arith();
        s_logic();
        s_bits();
        s_field();
        s_cmp();
        s_shift();
        s_muldiv();
        s_stall();
        close_out();
    end
endmodule // tb
